/* File: src/msrg_pkg.sv */
// Shared constants and carrier types for the module-stop and
// retention RAM write guard register bank.
// Assumes one clock domain and a plain byte-wide register port.
package msrg_pkg;

   // Register port widths
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // Register offsets on the plain port
   localparam logic [3:0] OFF_CLK_STOP = 4'h0;  // Serial FIFO channel clock stop
   localparam logic [3:0] OFF_RET_WE   = 4'h1;  // Retention RAM page write enables
   localparam logic [3:0] OFF_LR_ACC   = 4'h2;  // Large RAM page access enables
   localparam logic [3:0] OFF_LR_WR    = 4'h3;  // Large RAM page write enables

   // Values after reset
   localparam logic [7:0] RST_CLK_STOP = 8'h0f;  // All four channels stopped
   localparam logic [7:0] RST_RET_WE   = 8'h00;  // All pages write protected
   localparam logic [7:0] RST_LR_ACC   = 8'h07;  // Large RAM pages reachable
   localparam logic [7:0] RST_LR_WR    = 8'h07;  // Large RAM pages writable

   // Implemented bits; the rest read as zero
   localparam logic [7:0] MASK_CLK_STOP = 8'h0f;
   localparam logic [7:0] MASK_RET_WE   = 8'h0f;
   localparam logic [7:0] MASK_LR       = 8'h07;

   // Clock stop bit positions
   localparam int CH4_BIT = 3;
   localparam int CH5_BIT = 2;
   localparam int CH6_BIT = 1;
   localparam int CH7_BIT = 0;

   // Large RAM page bit positions
   localparam int LR_PAGE0 = 0;
   localparam int LR_PAGE1 = 1;
   localparam int LR_PAGE2 = 2;

   // Retention pages below this index sit in the first half
   localparam logic [1:0] FIRST_HALF_END = 2'h2;

   // Access request from the retention RAM port
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [1:0] page;
   } msrg_ram_req_t;

   // Verdict for that request, one cycle later
   typedef struct packed {
      logic valid;
      logic rdOk;
      logic wrOk;
   } msrg_ram_grant_t;

endpackage

/* File: src/msrg_top.sv */
// Module-stop bits for serial FIFO channels 4 to 7 and the write
// guard of the on-chip data-retention RAM, with its qualifying
// large RAM access and write enables.
// Assumes requests and register strobes come from logic on ref_clk;
// only nrst is asynchronous and is synchronised here.
`timescale 1ns/1ps

// What this block does
// - Channel 4 clock withheld while stop bit set
// - Channel 5 clock withheld while stop bit set
// - Channel 6 clock withheld while stop bit set
// - Channel 7 clock withheld while stop bit set
// - Upper four write-enable bits read zero
// - Page 3 writes need page 3 enable
// - Page 2 writes need page 2 enable
// - Page 1 writes need page 1 enable
// - Page 0 writes need page 0 enable
// - Large page 0 access off blocks all
// - Large page 0 write off blocks writes
// - Large page 1 access off blocks first half
// - Large page 1 write off blocks first half
// - Large page 2 access off blocks second half
// - Large page 2 write off blocks second half
module msrg_top
(
   input  wire logic                     ref_clk,
   input  wire logic                     nrst,
   input  wire logic [msrg_pkg::ADDR_W-1:0] regAddr,
   input  wire logic [msrg_pkg::DATA_W-1:0] regWdata,
   input  wire logic                     regWr,
   input  wire logic                     regRd,
   output logic [msrg_pkg::DATA_W-1:0]   regRdata,
   input  wire msrg_pkg::msrg_ram_req_t  ramReq,
   output msrg_pkg::msrg_ram_grant_t     ramGrant,
   output logic [3:0]                    chClkRun
);
   import msrg_pkg::*;

   // Synchronised reset
   logic       rstMeta_q;     // First stage, read only by second
   logic       rstSyncN_q;    // Reset used by all other logic

   // Software-visible state
   logic [7:0] clkStop_q;     // Channel clock stop bits
   logic [7:0] retWe_q;       // Retention page write enables
   logic [7:0] lrAcc_q;       // Large RAM access enables
   logic [7:0] lrWr_q;        // Large RAM write enables

   // Output flops
   logic [7:0]      rdata_q;  // Read data, valid one cycle after strobe
   msrg_ram_grant_t grant_q;  // Access verdict
   logic [3:0]      run_q;    // Per-channel clock enables

   // Guard terms
   logic firstHalf;           // Request targets the first half
   logic rdAllow;             // Reading the page is permitted
   logic wrAllow;             // Writing the page is permitted

   // Release reset through two flops so deassertion is clean
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rstMeta_q  <= 1'b0;
         rstSyncN_q <= 1'b0;
      end
      else
      begin
         rstMeta_q  <= 1'b1;
         rstSyncN_q <= rstMeta_q;
      end
   end

   // Channel clock stop register
   always_ff @(posedge ref_clk or negedge rstSyncN_q)
   begin
      if (!rstSyncN_q)
         clkStop_q <= RST_CLK_STOP;
      else if (regWr && regAddr == OFF_CLK_STOP)
         clkStop_q <= regWdata & MASK_CLK_STOP;
   end

   // Retention page write enables; reserved bits never stored
   always_ff @(posedge ref_clk or negedge rstSyncN_q)
   begin
      if (!rstSyncN_q)
         retWe_q <= RST_RET_WE;
      else if (regWr && regAddr == OFF_RET_WE)
         retWe_q <= regWdata & MASK_RET_WE;
   end

   // Large RAM access enables
   always_ff @(posedge ref_clk or negedge rstSyncN_q)
   begin
      if (!rstSyncN_q)
         lrAcc_q <= RST_LR_ACC;
      else if (regWr && regAddr == OFF_LR_ACC)
         lrAcc_q <= regWdata & MASK_LR;
   end

   // Large RAM write enables
   always_ff @(posedge ref_clk or negedge rstSyncN_q)
   begin
      if (!rstSyncN_q)
         lrWr_q <= RST_LR_WR;
      else if (regWr && regAddr == OFF_LR_WR)
         lrWr_q <= regWdata & MASK_LR;
   end

   // Read mux; unmapped offsets and idle cycles return zero
   always_ff @(posedge ref_clk or negedge rstSyncN_q)
   begin
      if (!rstSyncN_q)
         rdata_q <= 8'h00;
      else if (regRd)
      begin
         case (regAddr)
            OFF_CLK_STOP: rdata_q <= clkStop_q;
            OFF_RET_WE:   rdata_q <= retWe_q;
            OFF_LR_ACC:   rdata_q <= lrAcc_q;
            OFF_LR_WR:    rdata_q <= lrWr_q;
            default:      rdata_q <= 8'h00;
         endcase
      end
      else
         rdata_q <= 8'h00;
   end

   // Channel clock enables; registered so the gating cell sees no glitch
   always_ff @(posedge ref_clk or negedge rstSyncN_q)
   begin
      if (!rstSyncN_q)
         run_q <= 4'h0;
      else
      begin
         run_q[0] <= ~clkStop_q[CH4_BIT];
         run_q[1] <= ~clkStop_q[CH5_BIT];
         run_q[2] <= ~clkStop_q[CH6_BIT];
         run_q[3] <= ~clkStop_q[CH7_BIT];
      end
   end

   // Page-level qualification of the retention RAM
   always_comb
   begin
      firstHalf = ramReq.page < FIRST_HALF_END;
      // Large page 0 gates the whole RAM, then the half's own page
      rdAllow = lrAcc_q[LR_PAGE0] &&
                (firstHalf ? lrAcc_q[LR_PAGE1]
                           : lrAcc_q[LR_PAGE2]);
      wrAllow = rdAllow && lrWr_q[LR_PAGE0] &&
                (firstHalf ? lrWr_q[LR_PAGE1]
                           : lrWr_q[LR_PAGE2]) &&
                retWe_q[ramReq.page];
   end

   // Verdict flop; a refusal is just a low ok bit, no error path
   always_ff @(posedge ref_clk or negedge rstSyncN_q)
   begin
      if (!rstSyncN_q)
         grant_q <= '0;
      else
      begin
         grant_q.valid <= ramReq.valid;
         grant_q.rdOk  <= ramReq.valid && !ramReq.write && rdAllow;
         grant_q.wrOk  <= ramReq.valid && ramReq.write && wrAllow;
      end
   end

   assign regRdata = rdata_q;
   assign ramGrant = grant_q;
   assign chClkRun = run_q;

   // Checks on the driven outputs
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstSyncN_q);

   property p_ch4_stop;
      (regWr && regAddr == OFF_CLK_STOP) |-> ##2 (chClkRun[0] == !$past(regWdata[3], 2));
   endproperty
   a_ch4_stop: assert property (p_ch4_stop)
      else $error("channel 4 clock run wrong");

   property p_ch5_stop;
      (regWr && regAddr == OFF_CLK_STOP) |-> ##2 (chClkRun[1] == !$past(regWdata[2], 2));
   endproperty
   a_ch5_stop: assert property (p_ch5_stop)
      else $error("channel 5 clock run wrong");

   property p_ch6_stop;
      (regWr && regAddr == OFF_CLK_STOP) |-> ##2 (chClkRun[2] == !$past(regWdata[1], 2));
   endproperty
   a_ch6_stop: assert property (p_ch6_stop)
      else $error("channel 6 clock run wrong");

   property p_ch7_stop;
      (regWr && regAddr == OFF_CLK_STOP) |-> ##2 (chClkRun[3] == !$past(regWdata[0], 2));
   endproperty
   a_ch7_stop: assert property (p_ch7_stop)
      else $error("channel 7 clock run wrong");

   property p_resv_zero;
      (regRd && regAddr == OFF_RET_WE) |=> (regRdata[7:4] == 4'h0);
   endproperty
   a_resv_zero: assert property (p_resv_zero)
      else $error("reserved write-enable bits not zero");

   property p_page_we;
      (ramReq.valid && ramReq.write && !retWe_q[ramReq.page]) |=> !ramGrant.wrOk;
   endproperty
   a_page_we: assert property (p_page_we)
      else $error("write granted to protected page");

   property p_lr0_acc;
      (ramReq.valid && !lrAcc_q[LR_PAGE0]) |=> (!ramGrant.rdOk && !ramGrant.wrOk);
   endproperty
   a_lr0_acc: assert property (p_lr0_acc)
      else $error("access granted with large page 0 off");

   property p_lr0_wr;
      (ramReq.valid && !lrWr_q[LR_PAGE0]) |=> !ramGrant.wrOk;
   endproperty
   a_lr0_wr: assert property (p_lr0_wr)
      else $error("write granted with large page 0 write off");

   property p_lr1_acc;
      (ramReq.valid && ramReq.page < FIRST_HALF_END && !lrAcc_q[LR_PAGE1])
         |=> (!ramGrant.rdOk && !ramGrant.wrOk);
   endproperty
   a_lr1_acc: assert property (p_lr1_acc)
      else $error("first half access granted with large page 1 off");

   property p_lr1_wr;
      (ramReq.valid && ramReq.page < FIRST_HALF_END && !lrWr_q[LR_PAGE1]) |=> !ramGrant.wrOk;
   endproperty
   a_lr1_wr: assert property (p_lr1_wr)
      else $error("first half write granted with large page 1 write off");

   property p_lr2_acc;
      (ramReq.valid && ramReq.page >= FIRST_HALF_END && !lrAcc_q[LR_PAGE2])
         |=> (!ramGrant.rdOk && !ramGrant.wrOk);
   endproperty
   a_lr2_acc: assert property (p_lr2_acc)
      else $error("second half access granted with large page 2 off");

   property p_lr2_wr;
      (ramReq.valid && ramReq.page >= FIRST_HALF_END && !lrWr_q[LR_PAGE2]) |=> !ramGrant.wrOk;
   endproperty
   a_lr2_wr: assert property (p_lr2_wr)
      else $error("second half write granted with large page 2 write off");

   property p_grant_echo;
      ramReq.valid |=> (ramGrant.valid && !(ramGrant.rdOk && ramGrant.wrOk));
   endproperty
   a_grant_echo: assert property (p_grant_echo)
      else $error("verdict missing or both ok bits set");

endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the module-stop and retention RAM guard bank.
// Assumes msrg_pkg and msrg_top are compiled first; the bench drives every input port.
`timescale 1ns/1ps
module tb_top;
   import msrg_pkg::*;

   logic              ref_clk;     // 100 MHz clock
   logic              nrst;        // Async reset, active low
   logic [ADDR_W-1:0] regAddr;     // Register offset
   logic [DATA_W-1:0] regWdata;    // Write data
   logic              regWr;       // Write strobe
   logic              regRd;       // Read strobe
   logic [DATA_W-1:0] regRdata;    // Read data, one cycle after strobe
   msrg_ram_req_t     ramReq;      // Retention RAM request
   msrg_ram_grant_t   ramGrant;    // Verdict, one cycle later
   logic [3:0]        chClkRun;    // Channel clock enables
   logic [7:0]        mWe;         // Model of page write enables
   logic [7:0]        mAcc;        // Model of large RAM access enables
   logic [7:0]        mWr;         // Model of large RAM write enables
   int                num_errors;  // Mismatches seen
   int                compares;    // Comparisons made

   msrg_top uut
   (
      .ref_clk  (ref_clk),
      .nrst     (nrst),
      .regAddr  (regAddr),
      .regWdata (regWdata),
      .regWr    (regWr),
      .regRd    (regRd),
      .regRdata (regRdata),
      .ramReq   (ramReq),
      .ramGrant (ramGrant),
      .chClkRun (chClkRun)
   );

   // Free-running clock
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Register read data compare
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Channel clock enable compare; bit 0 is channel 4
   task automatic chk_run(input logic [3:0] got, input logic [3:0] exp);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("FAIL t=%0t run got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Access verdict compare: valid, read ok, write ok
   task automatic chk_grant(input logic [2:0] got, input logic [2:0] exp);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("FAIL t=%0t grant got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Verdict and end of run
   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // One-cycle write; the model keeps only implemented bits
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regWr    <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge ref_clk);
      regWr <= 1'b0;
      if (a == OFF_RET_WE)
         mWe = d & MASK_RET_WE;
      else if (a == OFF_LR_ACC)
         mAcc = d & MASK_LR;
      else if (a == OFF_LR_WR)
         mWr = d & MASK_LR;
   endtask

   // One-cycle read; data looked at in the single cycle it stands
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1 chk(regRdata, exp);
   endtask

   // Request held into the next cycle, so requests run back to back
   task automatic req(input logic w, input logic [1:0] p);
      logic acc;
      logic wok;
      acc = mAcc[0] & (p[1] ? mAcc[2] : mAcc[1]);
      wok = w & acc & mWr[0] & (p[1] ? mWr[2] : mWr[1]) & mWe[p];
      @(posedge ref_clk);
      ramReq <= '{valid: 1'b1, write: w, page: p};
      @(posedge ref_clk);
      #1 chk_grant(ramGrant, {1'b1, ~w & acc, wok});
   endtask

   // Reset held four cycles, first access well after release
   task automatic do_reset;
      @(posedge ref_clk);
      nrst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      mWe  = RST_RET_WE;
      mAcc = RST_LR_ACC;
      mWr  = RST_LR_WR;
   endtask

   // Values straight after reset
   task automatic defaults;
      rd(OFF_CLK_STOP, 8'h0f);
      chk_run(chClkRun, 4'h0);
      rd(OFF_RET_WE, 8'h00);
      rd(OFF_LR_ACC, RST_LR_ACC);
      rd(OFF_LR_WR, RST_LR_WR);
      rd(4'hc, 8'h00);
      for (int j = 0; j < 4; j++)
         req(1'b1, j[1:0]);
      ramReq <= '0;
   endtask

   // Main sequence
   initial
   begin
      nrst       = 1'b0;
      regAddr    = '0;
      regWdata   = '0;
      regWr      = 1'b0;
      regRd      = 1'b0;
      ramReq     = '0;
      num_errors = 0;
      compares   = 0;
      do_reset;
      defaults;
      // Every stop pattern, with ones thrown at the unused bits
      for (int v = 0; v < 16; v++)
      begin
         wr(OFF_CLK_STOP, 8'hf0 | 8'(v));
         rd(OFF_CLK_STOP, 8'(v));
         chk_run(chClkRun, ~{v[0], v[1], v[2], v[3]});
      end
      // Software keeps the reserved write-enable bits at zero
      wr(OFF_RET_WE, 8'h0a);
      rd(OFF_RET_WE, 8'h0a);
      // Unmapped write must not land anywhere
      wr(4'h7, 8'hff);
      rd(4'h7, 8'h00);
      rd(OFF_RET_WE, 8'h0a);
      // All enable combinations against every page and direction
      for (int k = 0; k < 1024; k++)
      begin
         wr(OFF_LR_ACC, 8'(k & 7));
         wr(OFF_LR_WR, 8'((k >> 3) & 7));
         wr(OFF_RET_WE, 8'(k >> 6));
         for (int j = 0; j < 8; j++)
            req(j[2], j[1:0]);
      end
      ramReq <= '0;
      // Second reset in mid-run restores everything
      do_reset;
      defaults;
      test_done;
   end

   // Sweep needs about 23k cycles; the 60k-cycle limit is over twice that, so reaching it means a hang
   initial
   begin
      #600000;
      num_errors++;
      test_done;
   end
endmodule
